// *** design/rfi_pkg.sv ***
// Overview of operation
// - Normal-mode watchdog reset equals low-voltage reset, flag set
// - Power-down watchdog clears only PC, SP; flag set
// - Power-on reset clears both status flags
// - Low-voltage reset keeps both status flags
// - Normal watchdog reset sets timeout, keeps powerdown flag
// - Power-down watchdog reset sets both flags
// - Power-on reset disables every interrupt
// - Power-on clears watchdog, then counting starts
// - Power-on switches off all timers
// - Power-on holds pulse generator counter stopped
// - Power-on makes every I/O pin input
// - Power-on points stack at top level
// - Reset values chosen by reset type
// - Power-on forces program counter to zero
// - Watchdog overflow triggers the timeout reset
package rfi_pkg;
  // ==========================================
  // Reset kinds
  typedef enum logic [2:0] {
    RFI_NONE,
    RFI_POR,
    RFI_LVR,
    RFI_WDT_NORM,
    RFI_WDT_PD
  } rfi_kind_t;

  localparam logic       FLAG_POR_VALUE = 1'h0;
  localparam logic       FLAG_SET_VALUE = 1'h1;
  localparam int         SYNC_STAGES    = 2;
  localparam logic [1:0] SYNC_IDLE      = 2'h0;
endpackage : rfi_pkg

// *** design/rfi_sync.sv ***
`timescale 1ns/10ps
module rfi_sync
  import rfi_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic [1:0] stage;
  logic [1:0] next_stage;

  // ==========================================
  // Two-stage synchroniser, first stage read only by second
  always_comb begin
    next_stage = {stage[0], async_i};
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage <= SYNC_IDLE;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_o = stage[1];
endmodule : rfi_sync

// *** design/rfi_reset_init.sv ***
`timescale 1ns/10ps
module rfi_reset_init
  import rfi_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic por_i,
  input  wire logic low_voltage_reset_i,
  input  wire logic wdt_overflow_i,
  input  wire logic powerdown_i,
  input  wire logic powerdown_flag_set_i,
  input  wire logic flags_clear_i,
  output logic      wdt_timeout_flag_o,
  output logic      powerdown_flag_o,
  output logic      pc_clear_o,
  output logic      sp_top_o,
  output logic      int_disable_o,
  output logic      wdt_clear_o,
  output logic      timers_off_o,
  output logic      pulse_pattern_generator_stop_o,
  output logic      ports_input_o,
  output logic      periph_reset_o,
  output logic [2:0] reset_kind_o
);
  logic      por_s;
  logic      lvr_s;
  logic      wdt_s;
  logic      pd_s;
  rfi_kind_t kind;
  rfi_kind_t next_kind;
  logic      to_flag;
  logic      next_to_flag;
  logic      pd_flag;
  logic      next_pd_flag;
  logic      full_rst;
  logic      next_full_rst;
  logic      pcsp_rst;
  logic      next_pcsp_rst;
  logic      wdt_prev;
  logic      wdt_rise;

  // ==========================================
  // Input synchronisers
  // Synchronised reset sources
  rfi_sync u_sync_por (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(por_i),               .sync_o(por_s));
  rfi_sync u_sync_lvr (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(low_voltage_reset_i), .sync_o(lvr_s));
  rfi_sync u_sync_wdt (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(wdt_overflow_i),      .sync_o(wdt_s));
  rfi_sync u_sync_pd  (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(powerdown_i),         .sync_o(pd_s));

  assign wdt_rise = wdt_s & ~wdt_prev;

  // ==========================================
  // Classify and update flags
  always_comb begin
    next_kind     = RFI_NONE;
    next_to_flag  = to_flag;
    next_pd_flag  = pd_flag;
    // Software clear loses to a hardware set in the same cycle
    if (flags_clear_i) begin
      next_to_flag = FLAG_POR_VALUE;
      next_pd_flag = FLAG_POR_VALUE;
    end
    if (powerdown_flag_set_i) begin
      next_pd_flag = FLAG_SET_VALUE;
    end
    if (por_s) begin
      next_kind = RFI_POR;
      next_to_flag = FLAG_POR_VALUE;
      next_pd_flag = FLAG_POR_VALUE;
    end else if (wdt_rise && pd_s) begin
      next_kind = RFI_WDT_PD;
      next_to_flag = FLAG_SET_VALUE;
      next_pd_flag = FLAG_SET_VALUE;
    end else if (wdt_rise) begin
      next_kind = RFI_WDT_NORM;
      next_to_flag = FLAG_SET_VALUE;
    end else if (lvr_s && !pd_s) begin
      next_kind = RFI_LVR;
    end
    // Same full reset as low voltage
    next_full_rst = (next_kind == RFI_POR) || (next_kind == RFI_LVR) || (next_kind == RFI_WDT_NORM);
    // Power-down timeout touches PC and SP only
    next_pcsp_rst = next_full_rst || (next_kind == RFI_WDT_PD);
  end

  // All controls change on one edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kind     <= RFI_POR;
      to_flag  <= FLAG_POR_VALUE;
      pd_flag  <= FLAG_POR_VALUE;
      full_rst <= 1'h1;
      pcsp_rst <= 1'h1;
      wdt_prev <= 1'h0;
    end else begin
      kind     <= next_kind;
      to_flag  <= next_to_flag;
      pd_flag  <= next_pd_flag;
      full_rst <= next_full_rst;
      pcsp_rst <= next_pcsp_rst;
      wdt_prev <= wdt_s;
    end
  end

  // ==========================================
  // Outputs straight from flops
  assign wdt_timeout_flag_o = to_flag;
  assign powerdown_flag_o   = pd_flag;
  assign pc_clear_o = pcsp_rst;
  assign sp_top_o = pcsp_rst;
  assign int_disable_o = full_rst;
  // Watchdog held clear while full_rst is high, released so counting resumes
  assign wdt_clear_o = full_rst;
  assign timers_off_o = full_rst;
  assign pulse_pattern_generator_stop_o = full_rst;
  assign ports_input_o  = full_rst;
  assign periph_reset_o = full_rst;
  assign reset_kind_o   = kind;

  // ==========================================
  // Checks
  // Power-on clears flags
  por_flags_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> (!to_flag && !pd_flag)) else $error("flags not cleared by power-on");
  lvr_flags_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (lvr_s && !por_s && !wdt_rise && !pd_s && !flags_clear_i && !powerdown_flag_set_i)
    |=> ($stable(to_flag) && $stable(pd_flag))) else $error("low-voltage reset changed flags");
  wdt_norm_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wdt_rise && !pd_s && !por_s && !flags_clear_i && !powerdown_flag_set_i)
    |=> (to_flag && $stable(pd_flag))) else $error("normal timeout flags wrong");
  wdt_pd_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wdt_rise && pd_s && !por_s) |=> (to_flag && pd_flag)) else $error("power-down timeout flags wrong");
  pd_scope_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wdt_rise && pd_s && !por_s) |=> (pc_clear_o && sp_top_o && !timers_off_o && !int_disable_o))
    else $error("power-down timeout touched other state");
  wdt_full_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wdt_rise && !pd_s) |=> (int_disable_o && timers_off_o && ports_input_o && wdt_clear_o))
    else $error("normal timeout not full reset");
  wdt_release_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (por_s ##1 !por_s && !wdt_s && !lvr_s) |=> !wdt_clear_o) else $error("watchdog clear held");
  por_core_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> (pc_clear_o && sp_top_o && pulse_pattern_generator_stop_o)) else $error("power-on core not reset");

  // ==========================================
  // Further checks on reset kind and controls
  // Power-on interrupts off
  por_int_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> int_disable_o) else $error("power-on left interrupts enabled");
  por_timer_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> timers_off_o) else $error("power-on left timers running");
  por_pattern_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> pulse_pattern_generator_stop_o) else $error("power-on left pattern generator running");
  por_ports_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> (ports_input_o && periph_reset_o)) else $error("power-on left ports driving");
  por_stack_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> sp_top_o) else $error("power-on left stack pointer");
  por_kind_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_s |=> (kind == RFI_POR)) else $error("power-on kind wrong");
  pd_kind_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wdt_rise && pd_s && !por_s) |=> (kind == RFI_WDT_PD)) else $error("power-down timeout kind wrong");
  norm_kind_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wdt_rise && !pd_s && !por_s) |=> (kind == RFI_WDT_NORM)) else $error("normal timeout kind wrong");
  // Low-voltage full reset, same controls as timeout
  lvr_full_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (lvr_s && !pd_s && !por_s && !wdt_rise)
    |=> (kind == RFI_LVR && int_disable_o && timers_off_o && ports_input_o && wdt_clear_o))
    else $error("low-voltage reset not full reset");
  lvr_pd_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (lvr_s && pd_s && !por_s && !wdt_rise) |=> (kind == RFI_NONE && !pc_clear_o))
    else $error("low-voltage reset acted in power-down");
  // Held overflow gives one timeout only
  wdt_once_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wdt_s && wdt_prev && !por_s && !lvr_s) |=> (kind == RFI_NONE && !pc_clear_o))
    else $error("held overflow repeated timeout");
  pd_set_wins_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (powerdown_flag_set_i && flags_clear_i && !por_s) |=> pd_flag)
    else $error("software clear beat hardware set");
  ctrl_agree_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (int_disable_o == timers_off_o) && (timers_off_o == ports_input_o) && (pc_clear_o == sp_top_o))
    else $error("reset controls out of step");
endmodule : rfi_reset_init

// *** testbench/rfi_reset_init_test.sv ***
`timescale 1ns/10ps
module rfi_reset_init_test;
  import rfi_pkg::*;
  // ==========================================
  // Rows: inputs {por, lvr, wdt, pd}, expected outputs, controls still up one edge later
  typedef struct packed {
    logic [3:0]  in;
    logic [12:0] exp;
    logic        pc2;
  } rfi_row_t;

  logic        clk_i;
  logic        reset_n_i;
  logic        por_i;
  logic        lvr_i;
  logic        wdt_i;
  logic        pd_i;
  logic        pd_set_i;
  logic        clr_i;
  logic [12:0] obs;
  int          fail_count;
  int          n_tests;
  int          cycles;
  // Order matters: flags carry over from row to row
  rfi_row_t    rows [7] = '{'{4'h4, 13'h07FA, 1'h1}, '{4'h2, 13'h17FB, 1'h0}, '{4'h4, 13'h17FA, 1'h1},
                            '{4'h3, 13'h1E04, 1'h0}, '{4'h5, 13'h1800, 1'h0}, '{4'h8, 13'h07F9, 1'h1},
                            '{4'h2, 13'h17FB, 1'h0}};

  rfi_reset_init dut (
    .clk_i                          (clk_i),
    .reset_n_i                      (reset_n_i),
    .por_i                          (por_i),
    .low_voltage_reset_i            (lvr_i),
    .wdt_overflow_i                 (wdt_i),
    .powerdown_i                    (pd_i),
    .powerdown_flag_set_i           (pd_set_i),
    .flags_clear_i                  (clr_i),
    .wdt_timeout_flag_o             (obs[12]),
    .powerdown_flag_o               (obs[11]),
    .pc_clear_o                     (obs[10]),
    .sp_top_o                       (obs[9]),
    .int_disable_o                  (obs[8]),
    .wdt_clear_o                    (obs[7]),
    .timers_off_o                   (obs[6]),
    .pulse_pattern_generator_stop_o (obs[5]),
    .ports_input_o                  (obs[4]),
    .periph_reset_o                 (obs[3]),
    .reset_kind_o                   (obs[2:0])
  );

  // ==========================================
  // Clock and hang guard
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Whole run is near 81 cycles, so 2000 leaves ample margin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Drives land 2 ns after the edge, clear of the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick

  // ==========================================
  // Main sequence
  initial begin
    {reset_n_i, por_i, lvr_i, wdt_i, pd_i, pd_set_i, clr_i} = 7'h00;
    tick(2);
    chk(obs, 13'h07F9);
    tick(3);
    reset_n_i = 1'h1;
    tick(1);
    chk(obs, 13'h0000);
    foreach (rows[i]) begin
      {por_i, lvr_i, wdt_i, pd_i} = rows[i].in;
      tick(3);
      chk(obs, rows[i].exp);
      tick(1);
      chk(obs, rows[i].pc2 ? rows[i].exp : (rows[i].exp & 13'h1800));
      {por_i, lvr_i, wdt_i, pd_i} = 4'h0;
      tick(6);
      chk(obs, rows[i].exp & 13'h1800);
    end
    // Hardware set of the power-down flag beats a software clear in the same cycle
    pd_set_i = 1'h1;
    clr_i    = 1'h1;
    tick(1);
    pd_set_i = 1'h0;
    clr_i    = 1'h0;
    chk(obs, 13'h0800);
    clr_i = 1'h1;
    tick(1);
    clr_i = 1'h0;
    chk(obs, 13'h0000);
    // Second reset in mid-run acts at once, release waits for an edge
    reset_n_i = 1'h0;
    #1;
    chk(obs, 13'h07F9);
    tick(2);
    reset_n_i = 1'h1;
    tick(1);
    chk(obs, 13'h0000);
    finish_test();
  end
endmodule : rfi_reset_init_test
